// ### fwci_host.sv
// Host controller that drives a word-wide flash over its asynchronous pins.
`timescale 1ns/1ps
`include "fwci_defs.svh"
module fwci_host
  import fwci_pkg::*;
#(
  parameter int POLL_LIMIT = 65535
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic [2:0] i_op,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_boot_locked,
  output logic o_ready,
  output logic o_done,
  output logic o_refused,
  output logic o_timeout,
  output logic [15:0] o_rdata,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic [15:0] o_addr,
  output logic [15:0] o_dq_out,
  output logic o_dq_oe,
  input wire logic [15:0] i_dq_in
);
  localparam logic [7:0] PULSE_CYC = 8'(`FWCI_WRITE_PULSE_CYC);
  localparam logic [7:0] HIGH_CYC = 8'(`FWCI_WRITE_HIGH_CYC);
  localparam logic [7:0] READ_CYC = 8'(`FWCI_READ_ACCESS_CYC + `FWCI_SYNC_SLACK_CYC);
  localparam logic [7:0] TOGGLE_CYC = 8'(`FWCI_TOGGLE_HIGH_CYC);

  fwci_state_t state_reg, state_next;
  logic [7:0] cnt_reg;
  logic [2:0] op_reg;
  logic have_prev_reg;
  logic prev_tog_reg;
  logic stable_reg;
  logic [31:0] polls_reg;
  logic [15:0] s1_reg, s2_reg, s3_reg;
  logic ready_reg, done_reg, refused_reg, timeout_reg;
  logic [15:0] rdata_reg;
  logic ce_n_reg, oe_n_reg, we_n_reg, dq_oe_reg;
  logic [15:0] addr_reg, dq_reg;

  wire is_write = (i_op == `FWCI_OP_WRITE) || (i_op == `FWCI_OP_ERASE_WR);
  // Boot block guard.
  wire in_boot = (i_addr >= `FWCI_BOOT_LO) && (i_addr <= `FWCI_BOOT_HI);
  // Boot lockout refusal; a locked part would silently ignore it otherwise.
  wire refuse = (i_op == `FWCI_OP_WRITE) && i_boot_locked && in_boot;
  wire cnt_done = (cnt_reg == 8'h00);
  wire sync_same = (s2_reg == s3_reg);
  wire cur_tog = s3_reg[`FWCI_TOGGLE_BIT];
  // stable toggle detect.
  // Compared as a new sample lands, so a read is never matched against itself.
  wire stable = have_prev_reg && (cur_tog == prev_tog_reg);
  wire poll_over = (polls_reg >= 32'(POLL_LIMIT));
  wire [15:0] cmd_addr = (i_op == `FWCI_OP_ERASE_WR) ? (i_addr & `FWCI_CMD_MASK) : i_addr;
  wire [15:0] cmd_data = (i_op == `FWCI_OP_ERASE_WR) ? {8'h00, i_wdata[7:0]} : i_wdata;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FWCI_IDLE: begin
        if (i_req && !refuse) begin
          state_next = is_write ? FWCI_SETUP : FWCI_RWAIT;
        end
      end
      FWCI_SETUP: state_next = FWCI_PULSE;
      FWCI_PULSE: begin
        if (cnt_done) begin
          state_next = FWCI_RECOVER;
        end
      end
      FWCI_RECOVER: begin
        if (cnt_done) begin
          state_next = FWCI_IDLE;
        end
      end
      FWCI_RWAIT: begin
        if (cnt_done && sync_same) begin
          state_next = FWCI_RDONE;
        end
      end
      FWCI_RDONE: begin
        if (op_reg == `FWCI_OP_POLL && !stable_reg && !poll_over) begin
          state_next = FWCI_HIGHP;
        end else begin
          state_next = FWCI_IDLE;
        end
      end
      FWCI_HIGHP: begin
        if (cnt_done) begin
          state_next = FWCI_RWAIT;
        end
      end
      default: state_next = FWCI_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_reg <= 16'h0000;
      s2_reg <= 16'h0000;
      s3_reg <= 16'h0000;
    end else begin
      s1_reg <= i_dq_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= FWCI_IDLE;
      cnt_reg <= 8'h00;
      op_reg <= `FWCI_OP_READ;
      have_prev_reg <= 1'b0;
      prev_tog_reg <= 1'b0;
      stable_reg <= 1'b0;
      polls_reg <= 32'h00000000;
      ready_reg <= 1'b0;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
      timeout_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      ce_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      dq_oe_reg <= 1'b0;
      addr_reg <= 16'h0000;
      dq_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
      ready_reg <= (state_next == FWCI_IDLE);
      if (!cnt_done) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
      case (state_reg)
        FWCI_IDLE: begin
          if (i_req && refuse) begin
            refused_reg <= 1'b1;
            ready_reg <= 1'b1;
          end else if (i_req) begin
            op_reg <= i_op;
            addr_reg <= cmd_addr;
            dq_reg <= cmd_data;
            have_prev_reg <= 1'b0;
            polls_reg <= 32'h00000000;
            timeout_reg <= 1'b0;
            ce_n_reg <= 1'b0;
            if (is_write) begin
              oe_n_reg <= 1'b1;
              dq_oe_reg <= 1'b1;
            end else begin
              oe_n_reg <= 1'b0;
              cnt_reg <= READ_CYC;
            end
          end
        end
        FWCI_SETUP: begin
          we_n_reg <= 1'b0;
          cnt_reg <= PULSE_CYC - 8'h01;
        end
        FWCI_PULSE: begin
          if (cnt_done) begin
            we_n_reg <= 1'b1;
            ce_n_reg <= 1'b1;
            cnt_reg <= HIGH_CYC - 8'h01;
          end
        end
        FWCI_RECOVER: begin
          if (cnt_done) begin
            dq_oe_reg <= 1'b0;
            done_reg <= 1'b1;
          end
        end
        FWCI_RWAIT: begin
          if (cnt_done && sync_same) begin
            rdata_reg <= s3_reg;
            prev_tog_reg <= cur_tog;
            stable_reg <= stable;
            have_prev_reg <= 1'b1;
            polls_reg <= polls_reg + 32'h00000001;
          end
        end
        FWCI_RDONE: begin
          // full high pulse.
          // Each poll read except the last ends with a full high pulse on both strobes.
          ce_n_reg <= 1'b1;
          oe_n_reg <= 1'b1;
          if (op_reg == `FWCI_OP_POLL && !stable_reg && !poll_over) begin
            cnt_reg <= TOGGLE_CYC;
          end else begin
            done_reg <= 1'b1;
            timeout_reg <= (op_reg == `FWCI_OP_POLL) && !stable_reg;
          end
        end
        FWCI_HIGHP: begin
          if (cnt_done) begin
            ce_n_reg <= 1'b0;
            oe_n_reg <= 1'b0;
            cnt_reg <= READ_CYC;
          end
        end
        default: begin
          ce_n_reg <= 1'b1;
        end
      endcase
    end
  end

  assign o_ready = ready_reg;
  assign o_done = done_reg;
  assign o_refused = refused_reg;
  assign o_timeout = timeout_reg;
  assign o_rdata = rdata_reg;
  assign o_ce_n = ce_n_reg;
  assign o_oe_n = oe_n_reg;
  assign o_we_n = we_n_reg;
  assign o_addr = addr_reg;
  assign o_dq_out = dq_reg;
  assign o_dq_oe = dq_oe_reg;
endmodule

// ### fwci_defs.svh
// Constants for the flash word command host controller.
`ifndef FWCI_DEFS_SVH
`define FWCI_DEFS_SVH
// Behaviour
// - Erase sequence ends with 10H for chip erase, 30H for main region erase.
// - During erase writes, output-enable is held high while write and select are low.
// - Toggle status bit advances on each read while an operation is busy.
// - Each toggled input meets a 150 ns minimum high pulse between status reads.
// - Completion is detected only when the toggle bit stops changing between reads.
// - Polling keeps the address constant across the whole polling sequence.
// - Command writes use only the low data byte and address bits 14 to 0.
`define FWCI_CLK_PERIOD_NS 8
`define FWCI_WRITE_PULSE_NS 90
`define FWCI_WRITE_HIGH_NS 90
`define FWCI_READ_ACCESS_NS 90
`define FWCI_TOGGLE_HIGH_PULSE_MIN_NS 150
`define FWCI_WRITE_PULSE_CYC ((`FWCI_WRITE_PULSE_NS + `FWCI_CLK_PERIOD_NS - 1) / `FWCI_CLK_PERIOD_NS)
`define FWCI_WRITE_HIGH_CYC ((`FWCI_WRITE_HIGH_NS + `FWCI_CLK_PERIOD_NS - 1) / `FWCI_CLK_PERIOD_NS)
`define FWCI_READ_ACCESS_CYC ((`FWCI_READ_ACCESS_NS + `FWCI_CLK_PERIOD_NS - 1) / `FWCI_CLK_PERIOD_NS)
`define FWCI_TOGGLE_HIGH_CYC ((`FWCI_TOGGLE_HIGH_PULSE_MIN_NS + `FWCI_CLK_PERIOD_NS - 1) / `FWCI_CLK_PERIOD_NS)
`define FWCI_SYNC_SLACK_CYC 3
`define FWCI_CMD_MASK 16'h7FFF
`define FWCI_CHIP_ERASE_CODE 8'h10
`define FWCI_MAIN_ERASE_CODE 8'h30
`define FWCI_TOGGLE_BIT 6
`define FWCI_OP_READ 3'h0
`define FWCI_OP_WRITE 3'h1
`define FWCI_OP_POLL 3'h2
`define FWCI_OP_ERASE_WR 3'h3
`define FWCI_ID_ADDR_MAKER 16'h0000
`define FWCI_ID_ADDR_PART 16'h0001
`define FWCI_BOOT_LO 16'h0000
`define FWCI_BOOT_HI 16'h1FFF
`endif

// ### fwci_pkg.sv
// Types for the flash word command host controller.
package fwci_pkg;
  typedef enum logic [2:0] {
    FWCI_IDLE = 3'b000,
    FWCI_SETUP = 3'b001,
    FWCI_PULSE = 3'b010,
    FWCI_RECOVER = 3'b011,
    FWCI_RWAIT = 3'b100,
    FWCI_RDONE = 3'b101,
    FWCI_HIGHP = 3'b110
  } fwci_state_t;
endpackage

// ### fwci_flash_model.sv
// Behavioural word flash that answers the host controller's strobes.
`timescale 1ns/1ps
module fwci_flash_model #(
  // Identification values and mode codes are arbitrary.
  parameter logic [7:0] ID_ENTRY_CODE = 8'hA1,
  parameter logic [7:0] ID_EXIT_CODE = 8'hA2,
  parameter logic [15:0] MAKER_CODE = 16'h00C5,
  parameter logic [15:0] PART_CODE = 16'h00D6
) (
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_dq,
  input wire logic [7:0] i_busy_reads,
  output logic [15:0] o_dq
);
  logic tog = 1'b0;
  logic [7:0] busy = 8'h00;
  logic [15:0] arr;
  logic [15:0] val;
  logic [15:0] arr_val;
  logic id_hit;
  logic id_mode = 1'b0;
  // leave identification mode.
  // Only the low byte is decoded, as for every command write.
  always @(posedge i_we_n) begin
    if (i_dq[7:0] == ID_ENTRY_CODE) id_mode = 1'b1;
    else if (i_dq[7:0] == ID_EXIT_CODE) id_mode = 1'b0;
  end
  always @(negedge i_we_n) busy = i_busy_reads;
  always @(negedge i_oe_n) begin
    if (busy != 8'h00) begin
      tog = ~tog;
      busy = busy - 8'h01;
    end
  end
  assign arr = i_addr ^ 16'h5A5A;
  assign arr_val = {arr[15:7], (busy != 8'h00) ? tog : arr[6], arr[5:0]};
  // codes on address zero and one.
  assign id_hit = id_mode && (i_addr[15:1] == 15'h0000);
  assign val = id_hit ? (i_addr[0] ? PART_CODE : MAKER_CODE) : arr_val;
  assign o_dq = (!i_ce_n && !i_oe_n && i_we_n) ? val : ~val;
endmodule

// ### fwci_host_asserts.sv
// Checker for the flash host controller pin behaviour.
`timescale 1ns/1ps
module fwci_host_asserts (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic [2:0] i_op,
  input wire logic [15:0] i_addr,
  input wire logic i_boot_locked,
  input wire logic o_ready,
  input wire logic o_done,
  input wire logic o_refused,
  input wire logic o_timeout,
  input wire logic o_ce_n,
  input wire logic o_oe_n,
  input wire logic o_we_n,
  input wire logic [15:0] o_addr,
  input wire logic [15:0] o_dq_out,
  input wire logic o_dq_oe
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic [4:0] hi_reg;
  // Saturates so a long idle gap counts as a full high pulse.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) hi_reg <= 5'h1F;
    else if (!o_oe_n) hi_reg <= 5'h00;
    else if (hi_reg != 5'h1F) hi_reg <= hi_reg + 5'h01;
  end
  AST_OE_HIGH_IN_WRITE: assert property (!o_we_n |-> o_oe_n && !o_ce_n) else $error("oe low in write");
  AST_OE_HIGH_PULSE: assert property ($fell(o_oe_n) |-> hi_reg >= 5'h13) else $error("oe high too short");
  AST_READ_ADDR: assert property (!o_oe_n && $past(!o_oe_n) |-> $stable(o_addr)) else $error("addr moved");
  AST_POLL_ADDR: assert property (!o_ready && $past(!o_ready) |-> $stable(o_addr)) else $error("poll addr moved");
  AST_READ_NO_DRIVE: assert property (!o_oe_n |-> !o_dq_oe) else $error("dq driven in read");
  AST_WE_PULSE: assert property ($fell(o_we_n) |-> ##11 !o_we_n) else $error("write pulse short");
  AST_DATA_HOLD: assert property (!o_we_n |-> o_dq_oe && $stable(o_dq_out)) else $error("data moved");
  AST_REFUSE: assert property (i_req && o_ready && i_op == 3'h1 && i_addr <= 16'h1FFF && i_boot_locked
    |=> o_refused && o_ce_n) else $error("no refusal");
  AST_REFUSE_QUIET: assert property (o_refused |-> o_ce_n && !o_dq_oe) else $error("pins moved");
  AST_WRITE_END: assert property (i_req && o_ready && i_op == 3'h3 |-> ##[20:30] o_done) else $error("no done");
  AST_TIMEOUT_DONE: assert property ($rose(o_timeout) |-> o_done) else $error("timeout alone");
endmodule
bind fwci_host fwci_host_asserts u_chk (.*);

// ### tb_top.sv
// Self-checking bench for the flash host controller.
`timescale 1ns/1ps
module tb_top;
  import fwci_pkg::*;
  logic clk, rst_n, req, lock, rdy, done, refd, tmo, ce_n, oe_n, we_n, dq_oe;
  logic [2:0] op;
  logic [15:0] addr, wd, rd, pa, dq_out, fdq, ca, cd;
  logic [7:0] busy;
  logic ce_seen, wr_bad;
  // Identification values and mode codes are arbitrary.
  localparam logic [7:0] ID_ENTRY = 8'hA1;
  localparam logic [7:0] ID_EXIT = 8'hA2;
  localparam logic [15:0] MAKER_ID = 16'h00C5;
  localparam logic [15:0] PART_ID = 16'h00D6;
  int errors = 0;
  int check_count = 0;
  fwci_host #(.POLL_LIMIT(8)) DUT (.i_sys_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_op(op),
    .i_addr(addr), .i_wdata(wd), .i_boot_locked(lock), .o_ready(rdy), .o_done(done),
    .o_refused(refd), .o_timeout(tmo), .o_rdata(rd), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n),
    .o_addr(pa), .o_dq_out(dq_out), .o_dq_oe(dq_oe), .i_dq_in(dq_oe ? dq_out : fdq));
  fwci_flash_model #(.ID_ENTRY_CODE(ID_ENTRY), .ID_EXIT_CODE(ID_EXIT), .MAKER_CODE(MAKER_ID),
    .PART_CODE(PART_ID)) u_flash (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(pa),
    .i_dq(dq_out), .i_busy_reads(busy), .o_dq(fdq));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic go(input logic [2:0] o, input logic [15:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) errors++;
    op = o;
    addr = a;
    wd = d;
    req = 1'b1;
    ce_seen = 1'b0;
    wr_bad = 1'b0;
    @(negedge clk);
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && refd !== 1'b1 && n < 3000) begin
      if (ce_n === 1'b0) ce_seen = 1'b1;
      if (we_n === 1'b0 && (oe_n !== 1'b1 || dq_oe !== 1'b1)) wr_bad = 1'b1;
      if (we_n === 1'b0) begin
        ca = pa;
        cd = dq_out;
      end
      @(negedge clk);
      n++;
    end
    if (n >= 3000) errors++;
  endtask
  task automatic t_cmd();
    go(3'h3, 16'hD555, 16'hAB10);
    chk(ca, 16'h5555);
    chk(cd, 16'h0010);
    chk({15'h0000, wr_bad}, 16'h0000);
    go(3'h3, 16'h2AAA, 16'hFF30);
    chk(cd, 16'h0030);
    chk({15'h0000, wr_bad}, 16'h0000);
  endtask
  task automatic t_lock();
    lock = 1'b1;
    go(3'h1, 16'h1FFF, 16'h1234);
    chk({refd, ce_seen}, 16'h0002);
    go(3'h1, 16'h2000, 16'h1234);
    chk({refd, done}, 16'h0001);
    lock = 1'b0;
  endtask
  task automatic t_ident();
    busy = 8'h00;
    go(3'h1, 16'h3000, {8'h00, ID_ENTRY});
    go(3'h0, 16'h0000, 16'h0000);
    chk(rd, MAKER_ID);
    // Idle between reads so output-enable stays high for a full pulse.
    repeat (20) @(negedge clk);
    go(3'h0, 16'h0001, 16'h0000);
    chk(rd, PART_ID);
    go(3'h1, 16'h3000, {8'h00, ID_EXIT});
    go(3'h0, 16'h0001, 16'h0000);
    chk(rd, 16'h5A5B);
  endtask
  task automatic t_poll(input logic [7:0] b, input logic [15:0] a, input logic exp_t);
    busy = b;
    go(3'h1, a, 16'h00C3);
    go(3'h2, a, 16'h0000);
    chk(tmo, exp_t);
    if (!exp_t) chk(rd, a ^ 16'h5A5A);
  endtask
  initial begin
    rst_n = 1'b0;
    req = 1'b0;
    op = 3'h0;
    addr = 16'h0000;
    wd = 16'h0000;
    lock = 1'b0;
    busy = 8'h00;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk(rdy, 1'b1);
    go(3'h0, 16'h0123, 16'h0000);
    chk(rd, 16'h5B79);
    t_cmd();
    t_lock();
    t_ident();
    t_poll(8'h03, 16'h4000, 1'b0);
    t_poll(8'h14, 16'h4100, 1'b1);
    close_out();
  end
  initial begin
    #400000;
    errors++;
    close_out();
  end
endmodule
